// ===== hw/bglue_top.sv
// board glue: chip_enable_space_1 split, four control registers and reset merge
//
// Function
// - registers answer at word address 0x300000
// - 16-bit access, only low byte meaningful
// - lower half flash, upper half registers
// - merge button and supervisors into board reset
// - exactly four control/status registers
// - led controls reset to zero, off
// - card hold and card outputs reset low
// - timer direction selects reset to input
// - monitor enabled, serial ports on-board at reset
// - revision register at offset 4, read-only
// - aux register at offset 6, mixed fields
// - dip states high bits, leds low bits
// - card present, status, writable card hold
// - monitor disable blocks core power reset
// - route bit one sends port to card
module bglue_top import bglue_pkg::*; #(
   parameter logic [3:0] LOGIC_REV = 4'h1,    // arbitrary value
   parameter logic [2:0] BOARD_REV = 3'h1,    // arbitrary value
   parameter int         RST_HOLD  = BGLUE_RST_HOLD
) (
   input  wire logic                    i_clk_sys,        // system clock, 100 MHz
   input  wire logic                    i_sys_rst,        // async reset, active high
   input  wire logic                    i_bus_ce1_n,      // chip_enable_space_1, low active
   input  wire logic                    i_bus_re_n,       // read strobe, low active
   input  wire logic                    i_bus_we_n,       // write strobe, low active
   input  wire logic [BGLUE_ADDR_W-1:0] i_bus_addr,       // word address within the space
   input  wire logic [BGLUE_DATA_W-1:0] i_bus_wdata,      // data pins, input side
   output logic      [BGLUE_DATA_W-1:0] o_bus_rdata,      // data pins, output side
   output logic                         o_bus_rdata_oe_n, // low while driving data
   output logic                         o_flash_ce_n,     // flash select, low active
   input  wire logic [3:0]              i_dip_switch,     // 1 = switch off
   input  wire logic                    i_card_present,   // 1 = card fitted
   input  wire logic [1:0]              i_card_status,    // card status lines
   input  wire logic                    i_core_pg,        // core power good
   input  wire logic                    i_button_n,       // reset button, low = pressed
   input  wire logic                    i_supply_ok,      // supervisor, high = good
   output logic      [3:0]              o_led_drive,      // 1 = led lit
   output logic                         o_card_rst,       // card reset, active high
   output logic      [1:0]              o_card_output,    // card control lines
   output logic      [1:0]              o_timer_dir,      // 1 = to output pin
   output logic                         o_serial_port_a_route, // 1 = to card
   output logic                         o_serial_port_b_route, // 1 = to card
   output logic                         o_board_rst       // global board reset
);

   bglue_bus_t                 bus_a;
   bglue_bus_t                 bus_s;
   bglue_stat_t                stat_a;
   bglue_stat_t                stat_s;
   logic                       sel_space;
   logic                       sel_reg;
   logic                       sel_flash;
   logic [BGLUE_OFS_W-1:0]     ofs;
   logic                       rd_act;
   logic                       wr_act;
   logic                       wr_act_q;
   logic                       wr_stb;
   logic [3:0]                 led_q;
   logic                       hold_q;
   logic [1:0]                 card_out_q;
   logic                       mon_dis_q;
   logic [1:0]                 timer_q;
   logic [1:0]                 route_q;
   logic [7:0]                 rd_byte;
   logic [BGLUE_DATA_W-1:0]    rdata_q;
   logic                       board_rst;

   assign bus_a = '{ce1_n: i_bus_ce1_n, re_n: i_bus_re_n, we_n: i_bus_we_n,
                    addr: i_bus_addr, wdata: i_bus_wdata};
   assign stat_a = '{dip: i_dip_switch, card_present: i_card_present, card_status: i_card_status,
                     core_pg: i_core_pg, button_n: i_button_n, supply_ok: i_supply_ok};

   // data is synced with its strobe; the bus keeps it steady well ahead of the strobe
   bglue_sync #(
      .W       ($bits(bglue_bus_t)),
      .RST_VAL (BGLUE_BUS_IDLE)
   ) u_bus_sync (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_async   (bus_a),
      .o_sync    (bus_s)
   );

   bglue_sync #(
      .W       ($bits(bglue_stat_t)),
      .RST_VAL (BGLUE_STAT_IDLE)
   ) u_stat_sync (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_async   (stat_a),
      .o_sync    (stat_s)
   );

   // space split on the top address bit; register window aliases over the upper half
   assign sel_space = ~bus_s.ce1_n;
   assign sel_reg   = sel_space & bus_s.addr[BGLUE_HALF_BIT];
   assign sel_flash = sel_space & ~bus_s.addr[BGLUE_HALF_BIT];
   assign ofs       = bus_s.addr[BGLUE_OFS_W-1:0];
   assign rd_act    = sel_reg & ~bus_s.re_n;
   assign wr_act    = sel_reg & ~bus_s.we_n;

   // flash select lags the pins by the sync depth; flash wait states must cover it
   assign o_flash_ce_n = ~sel_flash;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_act_q <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
      end
   end

   // one write per strobe, taken in the first cycle it is seen asserted
   assign wr_stb = wr_act & ~wr_act_q;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         led_q <= BGLUE_LED_RST;
      end else if (wr_stb && ofs == BGLUE_OFS_SWITCH_LED) begin
         led_q <= bus_s.wdata[BGLUE_SL_LED_LSB +: 4];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold_q     <= BGLUE_HOLD_RST;
         card_out_q <= BGLUE_CARD_OUT_RST;
      end else if (wr_stb && ofs == BGLUE_OFS_CARD) begin
         hold_q     <= bus_s.wdata[BGLUE_EC_HOLD];
         card_out_q <= {bus_s.wdata[BGLUE_EC_OUT1], bus_s.wdata[BGLUE_EC_OUT0]};
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mon_dis_q <= BGLUE_MON_DIS_RST;
         timer_q   <= BGLUE_TIMER_RST;
         route_q   <= BGLUE_ROUTE_RST;
      end else if (wr_stb && ofs == BGLUE_OFS_AUX) begin
         mon_dis_q <= bus_s.wdata[BGLUE_AX_MON_DIS];
         timer_q   <= {bus_s.wdata[BGLUE_AX_TIMER1], bus_s.wdata[BGLUE_AX_TIMER0]};
         route_q   <= {bus_s.wdata[BGLUE_AX_SP_B], bus_s.wdata[BGLUE_AX_SP_A]};
      end
   end
   // revision_info has no storage, so writes there fall through harmlessly

   always_comb begin
      rd_byte = 8'h00;
      if (ofs == BGLUE_OFS_SWITCH_LED) begin
         rd_byte[BGLUE_SL_DIP_LSB +: 4] = stat_s.dip;
         rd_byte[BGLUE_SL_LED_LSB +: 4] = led_q;
      end else if (ofs == BGLUE_OFS_CARD) begin
         rd_byte[BGLUE_EC_PRESENT] = stat_s.card_present;
         rd_byte[BGLUE_EC_STAT1]   = stat_s.card_status[1];
         rd_byte[BGLUE_EC_STAT0]   = stat_s.card_status[0];
         rd_byte[BGLUE_EC_HOLD]    = hold_q;
         rd_byte[BGLUE_EC_OUT1]    = card_out_q[1];
         rd_byte[BGLUE_EC_OUT0]    = card_out_q[0];
      end else if (ofs == BGLUE_OFS_REVISION) begin
         rd_byte[BGLUE_RV_LOGIC_LSB +: 4] = LOGIC_REV;
         rd_byte[BGLUE_RV_BOARD_LSB +: 3] = BOARD_REV;
      end else if (ofs == BGLUE_OFS_AUX) begin
         rd_byte[BGLUE_AX_CORE_PG] = stat_s.core_pg;
         rd_byte[BGLUE_AX_MON_DIS] = mon_dis_q;
         rd_byte[BGLUE_AX_TIMER1]  = timer_q[1];
         rd_byte[BGLUE_AX_TIMER0]  = timer_q[0];
         rd_byte[BGLUE_AX_SP_B]    = route_q[1];
         rd_byte[BGLUE_AX_SP_A]    = route_q[0];
      end
   end // only four offsets answer; others read zero

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= {8'h00, rd_byte};
      end
   end

   assign o_bus_rdata      = rdata_q;
   // enable follows the synced strobe so the pins float two cycles after the read ends
   assign o_bus_rdata_oe_n = ~rd_act;

   bglue_rst #(
      .HOLD (RST_HOLD)
   ) u_rst (
      .i_clk_sys   (i_clk_sys),
      .i_sys_rst   (i_sys_rst),
      .i_button_n  (stat_s.button_n),
      .i_supply_ok (stat_s.supply_ok),
      .i_core_pg   (stat_s.core_pg),
      .i_mon_dis   (mon_dis_q),
      .o_board_rst (board_rst)
   );

   assign o_board_rst           = board_rst;
   // the card leaves reset with the board; the hold bit can only add to it
   assign o_card_rst            = board_rst | hold_q;
   assign o_led_drive           = led_q;
   assign o_card_output         = card_out_q;
   assign o_timer_dir           = timer_q;
   assign o_serial_port_a_route = route_q[0];
   assign o_serial_port_b_route = route_q[1];

   // helper: high in the first cycle after reset release
   logic first_q;
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   AST_RESET_VALUES: assert property (
      first_q |-> (o_led_drive == 4'h0) && !hold_q && (o_card_output == 2'h0) && (o_timer_dir == 2'h0)
                  && !mon_dis_q && !o_serial_port_a_route && !o_serial_port_b_route)
      else $error("control bits not at reset values");

   AST_LED_WRITE: assert property (
      (wr_stb && ofs == BGLUE_OFS_SWITCH_LED) |=> (o_led_drive == $past(bus_s.wdata[3:0])))
      else $error("led write not taken");

   AST_ONE_WRITE: assert property (
      (wr_stb ##1 wr_act) |-> !wr_stb)
      else $error("second write within one strobe");

   AST_RO_IGNORED: assert property (
      (wr_stb && ofs == BGLUE_OFS_REVISION) |=> $stable(led_q) && $stable(hold_q) && $stable(card_out_q)
                                                && $stable(mon_dis_q) && $stable(timer_q) && $stable(route_q))
      else $error("write to revision register changed state");

   AST_REV_READ: assert property (
      (rd_act && ofs == BGLUE_OFS_REVISION) |=> (o_bus_rdata == {8'h00, LOGIC_REV, 1'b0, BOARD_REV}))
      else $error("revision read wrong");

   AST_UNMAPPED_ZERO: assert property (
      (rd_act && ofs[0]) |=> (o_bus_rdata == 16'h0000))
      else $error("odd offset returned data");

   AST_UPPER_ZERO: assert property (
      !o_bus_rdata_oe_n |-> (o_bus_rdata[15:8] == 8'h00))
      else $error("upper byte not zero");

   AST_NO_DRIVE: assert property (
      (!o_bus_rdata_oe_n |-> !bus_s.re_n && !bus_s.ce1_n && bus_s.addr[BGLUE_HALF_BIT]) and
      (!o_flash_ce_n |-> !bus_s.addr[BGLUE_HALF_BIT]))
      else $error("drive or flash select outside its half");

   AST_BUTTON_RESET: assert property (
      !stat_s.button_n |=> o_board_rst [*2])
      else $error("button did not reset board");

   AST_MON_GATE: assert property (
      (!stat_s.core_pg && !mon_dis_q) |=> o_board_rst)
      else $error("core power fail did not reset");

   AST_CARD_HOLD: assert property (
      hold_q |-> o_card_rst)
      else $error("card hold not applied");

   // a card register write lands in the hold bit and both card lines
   AST_CARD_WRITE: assert property (
      (wr_stb && ofs == BGLUE_OFS_CARD) |=> (hold_q == $past(bus_s.wdata[BGLUE_EC_HOLD]))
         && (o_card_output == {$past(bus_s.wdata[BGLUE_EC_OUT1]), $past(bus_s.wdata[BGLUE_EC_OUT0])}))
      else $error("card register write not taken");

   // every writable aux field follows the written byte; power good stays read-only
   AST_AUX_WRITE: assert property (
      (wr_stb && ofs == BGLUE_OFS_AUX) |=> (mon_dis_q == $past(bus_s.wdata[BGLUE_AX_MON_DIS]))
         && (o_timer_dir == {$past(bus_s.wdata[BGLUE_AX_TIMER1]), $past(bus_s.wdata[BGLUE_AX_TIMER0])})
         && (o_serial_port_b_route == $past(bus_s.wdata[BGLUE_AX_SP_B]))
         && (o_serial_port_a_route == $past(bus_s.wdata[BGLUE_AX_SP_A])))
      else $error("aux register write not taken");

   AST_DIP_READ: assert property (
      (rd_act && ofs == BGLUE_OFS_SWITCH_LED) |=> (o_bus_rdata[7:0] == {$past(stat_s.dip), $past(led_q)}))
      else $error("switch and led read wrong");

   // flash cycles must never reach the register file, whatever the low address bits say
   AST_FLASH_NO_WRITE: assert property (
      (sel_flash && !bus_s.we_n) |=> $stable(led_q) && $stable(hold_q) && $stable(card_out_q)
                                     && $stable(mon_dis_q) && $stable(timer_q) && $stable(route_q))
      else $error("flash write changed a register");

   // board reset only drops after a cycle in which every enabled source was quiet
   AST_QUIET_RELEASE: assert property (
      !o_board_rst |-> $past(stat_s.button_n) && $past(stat_s.supply_ok)
                       && ($past(stat_s.core_pg) || $past(mon_dis_q)))
      else $error("board reset dropped with a source active");

   COV_LED_WRITE: cover property (wr_stb && ofs == BGLUE_OFS_SWITCH_LED ##1 o_led_drive != 4'h0);
   COV_REV_READ:  cover property (rd_act && ofs == BGLUE_OFS_REVISION);
   COV_FLASH:     cover property (!o_flash_ce_n);
   COV_MON_DIS:   cover property (mon_dis_q && !stat_s.core_pg ##1 !o_board_rst);
   COV_CARD_HOLD: cover property (hold_q && !o_board_rst && o_card_rst);

endmodule

// ===== hw/bglue_pkg.sv
// package: board glue register map, field layout, reset values and pin bundles
package bglue_pkg;

   // word address bits of chip_enable_space_1 seen on the external_memory_interface
   localparam int BGLUE_ADDR_W   = 21;
   localparam int BGLUE_DATA_W   = 16;
   localparam int BGLUE_HALF_BIT = 20;            // set in upper half: 0x30_0000 - 0x20_0000

   // register word offsets, compared on the low address bits
   localparam int BGLUE_OFS_W = 3;
   localparam logic [BGLUE_OFS_W-1:0] BGLUE_OFS_SWITCH_LED = 3'h0;
   localparam logic [BGLUE_OFS_W-1:0] BGLUE_OFS_CARD       = 3'h2;
   localparam logic [BGLUE_OFS_W-1:0] BGLUE_OFS_REVISION   = 3'h4;
   localparam logic [BGLUE_OFS_W-1:0] BGLUE_OFS_AUX        = 3'h6;

   // switch_led_control fields
   localparam int BGLUE_SL_DIP_LSB = 4;
   localparam int BGLUE_SL_LED_LSB = 0;
   // expansion_card_control fields
   localparam int BGLUE_EC_PRESENT = 7;
   localparam int BGLUE_EC_STAT1   = 5;
   localparam int BGLUE_EC_STAT0   = 4;
   localparam int BGLUE_EC_HOLD    = 3;
   localparam int BGLUE_EC_OUT1    = 1;
   localparam int BGLUE_EC_OUT0    = 0;
   // revision_info fields
   localparam int BGLUE_RV_LOGIC_LSB = 4;
   localparam int BGLUE_RV_BOARD_LSB = 0;
   // aux_routing_control fields
   localparam int BGLUE_AX_CORE_PG  = 5;
   localparam int BGLUE_AX_MON_DIS  = 4;
   localparam int BGLUE_AX_TIMER1   = 3;
   localparam int BGLUE_AX_TIMER0   = 2;
   localparam int BGLUE_AX_SP_B     = 1;
   localparam int BGLUE_AX_SP_A     = 0;

   // reset values
   localparam logic [3:0] BGLUE_LED_RST      = 4'h0;
   localparam logic       BGLUE_HOLD_RST     = 1'b0;
   localparam logic [1:0] BGLUE_CARD_OUT_RST = 2'h0;
   localparam logic       BGLUE_MON_DIS_RST  = 1'b0;
   localparam logic [1:0] BGLUE_TIMER_RST    = 2'h0;
   localparam logic [1:0] BGLUE_ROUTE_RST    = 2'h0;

   // cycles the board reset stays up after every source has gone quiet
   localparam int BGLUE_RST_HOLD = 16;

   typedef struct packed {
      logic                    ce1_n;
      logic                    re_n;
      logic                    we_n;
      logic [BGLUE_ADDR_W-1:0] addr;
      logic [BGLUE_DATA_W-1:0] wdata;
   } bglue_bus_t;

   typedef struct packed {
      logic [3:0] dip;
      logic       card_present;
      logic [1:0] card_status;
      logic       core_pg;
      logic       button_n;
      logic       supply_ok;
   } bglue_stat_t;

   localparam bglue_bus_t BGLUE_BUS_IDLE = '{ce1_n: 1'b1, re_n: 1'b1, we_n: 1'b1, addr: '0, wdata: '0};
   localparam bglue_stat_t BGLUE_STAT_IDLE = '{dip: 4'hF, card_present: 1'b0, card_status: 2'h0,
                                               core_pg: 1'b1, button_n: 1'b1, supply_ok: 1'b1};

endpackage

// ===== hw/bglue_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
module bglue_sync import bglue_pkg::*; #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         i_clk_sys, // system clock
   input  wire logic         i_sys_rst, // async reset, active high
   input  wire logic [W-1:0] i_async,   // pin levels
   output logic      [W-1:0] o_sync     // synchronised levels
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

// ===== hw/bglue_rst.sv
// merges button, supply and core monitor into one stretched board reset
module bglue_rst import bglue_pkg::*; #(
   parameter int HOLD = BGLUE_RST_HOLD
) (
   input  wire logic i_clk_sys,    // system clock
   input  wire logic i_sys_rst,    // async reset, active high
   input  wire logic i_button_n,   // synced push button, low = pressed
   input  wire logic i_supply_ok,  // synced supervisor, high = good
   input  wire logic i_core_pg,    // synced core power good
   input  wire logic i_mon_dis,    // core_monitor_disable register bit
   output logic      o_board_rst   // global board reset, active high
);

   localparam int CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

   logic          req;
   logic [CW-1:0] cnt_q;
   logic          rst_q;

   // core monitor only counts while not disabled
   assign req = ~i_button_n | ~i_supply_ok | (~i_core_pg & ~i_mon_dis);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= HOLD_C;
      end else if (req) begin
         cnt_q <= HOLD_C;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rst_q <= 1'b1;
      end else begin
         rst_q <= req | (cnt_q != '0);
      end
   end

   assign o_board_rst = rst_q;

endmodule

// ===== tb/bglue_external_memory_interface_model.sv
// asynchronous memory master model standing in for the processor's external memory interface
module bglue_external_memory_interface_model import bglue_pkg::*; (
   input  wire logic                    i_clk_sys,    // system clock
   input  wire logic [BGLUE_DATA_W-1:0] i_rdata,      // data pins from the glue
   input  wire logic                    i_rdata_oe_n, // glue drives data while low
   input  wire logic                    i_flash_ce_n, // flash select from the glue
   output bglue_bus_t                   o_bus         // strobes, address and write data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial o_bus = BGLUE_BUS_IDLE;

   // one 16-bit cycle; strobe held four edges so the synchronised copy is seen and read data settles
   task automatic access(input  logic                    wr,
                         input  logic [BGLUE_ADDR_W-1:0] addr,
                         input  logic [BGLUE_DATA_W-1:0] wdata,
                         output logic [BGLUE_DATA_W-1:0] rdata,
                         output logic                    oe_seen_n,
                         output logic                    flash_seen_n);
      @(posedge i_clk_sys);
      #1;
      o_bus.ce1_n = 1'b0;
      o_bus.re_n  = wr;
      o_bus.we_n  = !wr;
      o_bus.addr  = addr;
      o_bus.wdata = wr ? wdata : ~o_bus.wdata;
      repeat (4) @(posedge i_clk_sys);
      rdata        = i_rdata;
      oe_seen_n    = i_rdata_oe_n;
      flash_seen_n = i_flash_ce_n;
      #1;
      // released lines show the inverse so a stale capture cannot pass by luck
      o_bus.ce1_n = 1'b1;
      o_bus.re_n  = 1'b1;
      o_bus.we_n  = 1'b1;
      o_bus.addr  = ~o_bus.addr;
      o_bus.wdata = ~o_bus.wdata;
      repeat (3) @(posedge i_clk_sys);
      // hand back off the edge so the caller's pin changes never race the synchronisers
      #1;
   endtask
endmodule

// ===== tb/bglue_top_tb_top.sv
// self-checking testbench for the board glue register bank
module bglue_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import bglue_pkg::*;

   localparam logic [3:0]              LREV     = 4'h9;      // arbitrary value
   localparam logic [2:0]              BREV     = 3'h5;      // arbitrary value
   localparam logic [BGLUE_ADDR_W-1:0] REG_BASE = 21'h10_0000;

   logic                    clk       = 1'b0;
   logic                    rst       = 1'b1;
   bglue_bus_t              bus;
   logic [BGLUE_DATA_W-1:0] rdata;
   logic                    oe_n;
   logic                    flash_n;
   logic [3:0]              dip       = 4'hA;
   logic                    present   = 1'b0;
   logic [1:0]              status    = 2'h0;
   logic                    core_pg   = 1'b1;
   logic                    button_n  = 1'b1;
   logic                    supply_ok = 1'b1;
   logic [3:0]              led;
   logic                    card_rst;
   logic [1:0]              card_out;
   logic [1:0]              timer;
   logic                    spa;
   logic                    spb;
   logic                    board_rst;
   logic [15:0]             got;
   logic                    oe_seen;
   logic                    fl_seen;
   int                      fail_count = 0;
   int                      n_tests    = 0;

   always #5 clk = ~clk;

   bglue_external_memory_interface_model u_external_memory_interface (.i_clk_sys(clk), .i_rdata(rdata), .i_rdata_oe_n(oe_n), .i_flash_ce_n(flash_n),
                            .o_bus(bus));

   bglue_top #(.LOGIC_REV(LREV), .BOARD_REV(BREV), .RST_HOLD(2)) DUT (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_bus_ce1_n(bus.ce1_n), .i_bus_re_n(bus.re_n),
      .i_bus_we_n(bus.we_n), .i_bus_addr(bus.addr), .i_bus_wdata(bus.wdata), .o_bus_rdata(rdata),
      .o_bus_rdata_oe_n(oe_n), .o_flash_ce_n(flash_n), .i_dip_switch(dip), .i_card_present(present),
      .i_card_status(status), .i_core_pg(core_pg), .i_button_n(button_n), .i_supply_ok(supply_ok),
      .o_led_drive(led), .o_card_rst(card_rst), .o_card_output(card_out), .o_timer_dir(timer),
      .o_serial_port_a_route(spa), .o_serial_port_b_route(spb), .o_board_rst(board_rst));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [2:0] ofs, output logic [15:0] d);
      u_external_memory_interface.access(1'b0, REG_BASE | {18'h0_0000, ofs}, 16'h0000, d, oe_seen, fl_seen);
   endtask

   task automatic wr(input logic [2:0] ofs, input logic [15:0] d);
      u_external_memory_interface.access(1'b1, REG_BASE | {18'h0_0000, ofs}, d, got, oe_seen, fl_seen);
   endtask

   // bounded wait for the board reset to reach a level, leaving time just past an edge
   task automatic wait_rst(input logic lvl);
      int k;
      k = 0;
      while (board_rst !== lvl && k < 40) begin
         @(posedge clk);
         k++;
      end
      #1;
   endtask

   task automatic report_and_stop;
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #100_000;
      fail_count++;
      report_and_stop;
   end

   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      check(board_rst, 1'b1);
      wait_rst(1'b0);
      check(board_rst, 1'b0);
      check({led, card_rst, card_out, timer, spa, spb}, 16'h0000);
      rd(3'h0, got);
      check(got, {8'h00, dip, 4'h0});
      check({oe_seen, fl_seen}, 2'b01);
      rd(3'h2, got);
      check(got, 16'h0000);
      rd(3'h4, got);
      check(got, {8'h00, LREV, 1'b0, BREV});
      rd(3'h6, got);
      check(got, 16'h0020);
      // upper byte of write data is junk and must not leak back
      wr(3'h0, 16'hAB05);
      check(led, 4'h5);
      check(oe_seen, 1'b1);
      rd(3'h0, got);
      check(got, {8'h00, dip, 4'h5});
      wr(3'h0, 16'h00FA);
      check(led, 4'hA);
      present = 1'b1;
      status  = 2'b10;
      wr(3'h2, 16'hFFFF);
      check({card_rst, card_out}, 3'b111);
      rd(3'h2, got);
      check(got, 16'h00AB);
      wr(3'h2, 16'h0000);
      check({card_rst, card_out}, 3'b000);
      present = 1'b0;
      wr(3'h4, 16'hFFFF);
      rd(3'h4, got);
      check(got, {8'h00, LREV, 1'b0, BREV});
      for (int i = 0; i < 4; i++) begin
         wr(3'h6, 16'h0001 << i);
         check({timer, spb, spa}, 4'h1 << i);
         rd(3'h6, got);
         check(got, 16'h0020 | (16'h0001 << i));
      end
      wr(3'h6, 16'h00FF);
      rd(3'h6, got);
      check(got, 16'h003F);
      // monitor disabled: a core power drop must not reset the board
      core_pg = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check(board_rst, 1'b0);
      rd(3'h6, got);
      check(got, 16'h001F);
      wr(3'h6, 16'h0000);
      wait_rst(1'b1);
      check({board_rst, card_rst}, 2'b11);
      core_pg = 1'b1;
      wait_rst(1'b0);
      check(board_rst, 1'b0);
      for (int s = 0; s < 2; s++) begin
         if (s == 0)
            button_n = 1'b0;
         else
            supply_ok = 1'b0;
         wait_rst(1'b1);
         check(board_rst, 1'b1);
         button_n  = 1'b1;
         supply_ok = 1'b1;
         wait_rst(1'b0);
         check(board_rst, 1'b0);
      end
      wr(3'h0, 16'h0003);
      for (int o = 1; o < 8; o += 2) begin
         wr(3'(o), 16'h00FF);
         rd(3'(o), got);
         check(got, 16'h0000);
      end
      check({led, timer, spb, spa}, 8'h30);
      // lower half belongs to the flash: no register action, no data drive
      u_external_memory_interface.access(1'b1, 21'h00_0000, 16'h000C, got, oe_seen, fl_seen);
      check({led, fl_seen}, 5'b0011_0);
      u_external_memory_interface.access(1'b0, 21'h00_0000, 16'h0000, got, oe_seen, fl_seen);
      check({oe_seen, fl_seen}, 2'b10);
      check({oe_n, flash_n}, 2'b11);
      rd(3'h0, got);
      check(got, {8'h00, dip, 4'h3});
      report_and_stop;
   end
endmodule
